// >>> cri_top.sv
/*
  Receive interrupt enable block of a CAN controller, with its flag
  registers, transmit enables, request gating and interrupt summary.
  Assumes APB on clk; events, counts and init handshake come from logic
  on the same clock, so none of them is synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cri_params.svh"
module cri_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire cri_pkg::cri_addr_t paddr,
  input wire cri_pkg::cri_word_t pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic init_request,
  input wire logic init_acknowledge,
  input wire logic wakeup_event,
  input wire logic overrun_event,
  input wire logic rx_full_event,
  input wire logic [2:0] tx_empty_set,
  input wire logic [7:0] rx_err_count,
  input wire logic [8:0] tx_err_count,
  output logic wakeup_irq,
  output logic error_irq,
  output logic rx_irq,
  output logic tx_irq,
  output logic irq
);
  import cri_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // State and local signals.

  // All state outside the submodules in one word.
  typedef struct packed {
    logic [7:0] rier;   // The rx_interrupt_enable register.
    logic [2:0] tflag;  // Transmit buffer empty flags.
    logic [2:0] tie;    // Transmit empty interrupt enables.
    logic wflag;        // Wake-up flag.
    logic sflag;        // Status change flag.
    logic oflag;        // Overrun flag.
    logic fflag;        // Receive full flag.
    logic [3:0] ists;   // Sticky request summary.
    logic [3:0] ien;    // Summary enables.
    logic wk_irq;       // Registered wake-up request.
    logic er_irq;       // Registered error request.
    logic rx_irq;       // Registered receiver request.
    logic tx_irq;       // Registered transmit request.
    logic irq;          // Registered summary interrupt.
  } cri_top_s;

  cri_top_s st_q, st_d;    // Current and next state.
  cri_if bus();            // Link to the APB front end.
  logic init_mode;         // Initialization mode is active.
  logic init_free;         // Handshake fully released.
  logic tx_boff;           // Transmitter is bus-off.
  cri_code_t rx_code;      // Receiver state code.
  cri_code_t tx_code;      // Transmitter state code.
  logic rx_chg;            // Receiver change qualifies.
  logic tx_chg;            // Transmitter change qualifies.
  logic wr_rflg;           // Write to the receive flags.
  logic wr_rier;           // Write to the receive enables.
  logic wr_tflg;           // Write to the transmit flags.
  logic wr_tier;           // Write to the transmit enables.
  logic wr_iclr;           // Write to the summary clear.
  logic wr_ien;            // Write to the summary enables.
  logic [3:0] req;         // Live requests, one per line.
  logic [5:0] widx;        // Word index of the access.

  //////////////////////////////////////////////////////////////////////
  // Submodules.

  // APB front end.
  cri_apb u_apb (
    .clk(clk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus.slv)
  );

  // Bus-off is reached only through the transmit count.
  assign tx_boff = tx_err_count >= `CRI_BOFF_CNT;

  // Receiver tracker mirrors transmitter bus-off as its own code.
  cri_stat u_rx (
    .clk(clk),
    .resetn(resetn),
    .count({1'b0, rx_err_count}),
    .bus_off(tx_boff),
    .sens(st_q.rier[`CRI_F_RSENS]),
    .hold(st_q.sflag),
    .code(rx_code),
    .change(rx_chg)
  );

  // Transmitter tracker.
  cri_stat u_tx (
    .clk(clk),
    .resetn(resetn),
    .count(tx_err_count),
    .bus_off(tx_boff),
    .sens(st_q.rier[`CRI_F_TSENS]),
    .hold(st_q.sflag),
    .code(tx_code),
    .change(tx_chg)
  );

  //////////////////////////////////////////////////////////////////////
  // Address decode and read path.

  assign init_mode = init_request & init_acknowledge;
  // A half-done handshake also blocks writes, except to the summary clear and enables.
  assign init_free = ~init_request & ~init_acknowledge;
  assign widx = bus.addr[7:2];

  // Read mux; misaligned or unknown words answer with an error.
  always_comb begin
    bus.rdata = 8'h00;
    bus.err = 1'b0;
    if (bus.addr[1:0] != 2'h0) begin
      bus.err = 1'b1;
    end else begin
      case (widx)
        `CRI_IDX_RFLG: bus.rdata = {st_q.wflag, st_q.sflag, rx_code,
                                    tx_code, st_q.oflag, st_q.fflag};
        `CRI_IDX_RIER: bus.rdata = st_q.rier;
        `CRI_IDX_TFLG: bus.rdata = {5'h00, st_q.tflag};
        `CRI_IDX_TIER: bus.rdata = {5'h00, st_q.tie};
        `CRI_IDX_ISTS: bus.rdata = {4'h0, st_q.ists};
        `CRI_IDX_ICLR: bus.rdata = 8'h00;  // Write-only word.
        `CRI_IDX_IEN: bus.rdata = {4'h0, st_q.ien};
        default: bus.err = 1'b1;
      endcase
    end
  end

  // Write strobes per register.
  assign wr_rflg = bus.wr & ~bus.err & (widx == `CRI_IDX_RFLG);
  assign wr_rier = bus.wr & ~bus.err & (widx == `CRI_IDX_RIER);
  assign wr_tflg = bus.wr & ~bus.err & (widx == `CRI_IDX_TFLG);
  assign wr_tier = bus.wr & ~bus.err & (widx == `CRI_IDX_TIER);
  assign wr_iclr = bus.wr & ~bus.err & (widx == `CRI_IDX_ICLR);
  assign wr_ien = bus.wr & ~bus.err & (widx == `CRI_IDX_IEN);

  //////////////////////////////////////////////////////////////////////
  // Request gating.

  // Each line is flag AND enable; the error line ORs two sources, the transmit line three.
  always_comb begin
    req[0] = st_q.wflag & st_q.rier[`CRI_B_WUP];
    req[1] = (st_q.sflag & st_q.rier[`CRI_B_CSC]) |
             (st_q.oflag & st_q.rier[`CRI_B_OVR]);
    req[2] = st_q.fflag & st_q.rier[`CRI_B_RXF];
    req[3] = |(st_q.tflag & st_q.tie);
  end

  //////////////////////////////////////////////////////////////////////
  // Next state.

  // Every set is applied after its clear, so an event never gets lost.
  always_comb begin
    st_d = st_q;
    // Enables: writes only with the handshake released.
    if (wr_rier && init_free) begin
      st_d.rier = bus.wdata;
    end
    // Init mode clears the enables but keeps both sensitivities.
    if (init_mode) begin
      st_d.rier = (st_q.rier & `CRI_SENS_MASK) |
                  (`CRI_RIER_RST & ~`CRI_SENS_MASK);
    end
    // Receive flags: write one to clear.
    if (wr_rflg && init_free) begin
      st_d.wflag = st_q.wflag & ~bus.wdata[`CRI_B_WUP];
      st_d.sflag = st_q.sflag & ~bus.wdata[`CRI_B_CSC];
      st_d.oflag = st_q.oflag & ~bus.wdata[`CRI_B_OVR];
      st_d.fflag = st_q.fflag & ~bus.wdata[`CRI_B_RXF];
    end
    st_d.wflag = st_d.wflag | wakeup_event;
    st_d.sflag = st_d.sflag | rx_chg | tx_chg;
    st_d.oflag = st_d.oflag | overrun_event;
    st_d.fflag = st_d.fflag | rx_full_event;
    // Transmit flags: ones clear, zeros do nothing.
    if (wr_tflg && init_free) begin
      st_d.tflag = st_q.tflag & ~bus.wdata[`CRI_F_TXE];
    end
    st_d.tflag = st_d.tflag | tx_empty_set;
    // Transmit enables.
    if (wr_tier && init_free) begin
      st_d.tie = bus.wdata[`CRI_F_TXE];
    end
    // Transmit side is held at reset during init mode.
    if (init_mode) begin
      st_d.tflag = `CRI_TFLG_RST;
      st_d.tie = '0;
    end
    // Summary: sticky per line, cleared by writing ones.
    if (wr_iclr) begin
      st_d.ists = st_q.ists & ~bus.wdata[`CRI_F_IRQ];
    end
    st_d.ists = st_d.ists | req;
    if (wr_ien) begin
      st_d.ien = bus.wdata[`CRI_F_IRQ];
    end
    // Outputs lag their causes by one cycle to come from flops.
    st_d.wk_irq = req[0];
    st_d.er_irq = req[1];
    st_d.rx_irq = req[2];
    st_d.tx_irq = req[3];
    st_d.irq = |(st_q.ists & st_q.ien);
  end

  // State register; buffers start out empty.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.rier <= `CRI_RIER_RST;
      st_q.tflag <= `CRI_TFLG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign wakeup_irq = st_q.wk_irq;
  assign error_irq = st_q.er_irq;
  assign rx_irq = st_q.rx_irq;
  assign tx_irq = st_q.tx_irq;
  assign irq = st_q.irq;

  //////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rier_init_hold_a: assert property (
    init_mode |=> (st_q.rier & ~`CRI_SENS_MASK) == `CRI_RIER_RST)
    else $error("enables not held at reset in init mode");
  rier_wr_block_a: assert property (
    (wr_rier && !init_free && !init_mode) |=> $stable(st_q.rier))
    else $error("enable write taken during init handshake");
  sens_keep_a: assert property (
    (init_mode && !wr_rier) |=>
      $stable(st_q.rier[`CRI_F_RSENS]) &&
      $stable(st_q.rier[`CRI_F_TSENS]))
    else $error("sensitivity lost in init mode");
  wake_gate_a: assert property (
    (st_q.wflag && st_q.rier[`CRI_B_WUP]) |=> wakeup_irq)
    else $error("wake-up request missing");
  err_gate_a: assert property (
    (!st_q.rier[`CRI_B_CSC] && !st_q.rier[`CRI_B_OVR]) |=> !error_irq)
    else $error("error request while both enables off");
  rx_gate_a: assert property (
    (st_q.fflag && st_q.rier[`CRI_B_RXF]) |=> rx_irq)
    else $error("receiver request missing");
  tx_w1c_a: assert property (
    (wr_tflg && init_free && bus.wdata[0] && !tx_empty_set[0])
      |=> !st_q.tflag[0])
    else $error("transmit flag not cleared by one");
  tx_gate_a: assert property (
    (st_q.tie == 3'h0) |=> !tx_irq)
    else $error("transmit request with enables off");
  sum_irq_a: assert property (
    (|(st_q.ists & st_q.ien)) |=> irq)
    else $error("summary interrupt missing");

  chg_cov_c: cover property (rx_chg ##1 st_q.sflag ##[1:20] !st_q.sflag);
  init_cov_c: cover property (init_mode ##1 !init_mode ##[1:10] wr_rier);
  err_cov_c: cover property (error_irq && st_q.oflag);
  tx_cov_c: cover property (wr_tflg ##1 tx_irq == 1'b0);
endmodule : cri_top
`default_nettype wire

// >>> cri_params.svh
/*
  Constants for the receive interrupt enable block: register indices,
  field positions, reset values and error-count thresholds.
  Assumes inclusion by every design file that needs a number.
*/
`ifndef CRI_PARAMS_SVH
`define CRI_PARAMS_SVH

// Register word indices; byte address is four times the index.
`define CRI_IDX_RFLG 6'h04
`define CRI_IDX_RIER 6'h05
`define CRI_IDX_TFLG 6'h06
`define CRI_IDX_TIER 6'h07
`define CRI_IDX_ISTS 6'h08
`define CRI_IDX_ICLR 6'h09
`define CRI_IDX_IEN 6'h0a

// Enable register field positions.
`define CRI_B_WUP 7
`define CRI_B_CSC 6
`define CRI_F_RSENS 5:4
`define CRI_F_TSENS 3:2
`define CRI_B_OVR 1
`define CRI_B_RXF 0
// Sensitivity fields survive initialization mode.
`define CRI_SENS_MASK 8'h3c

// Flag and summary register field positions.
`define CRI_F_RCODE 5:4
`define CRI_F_TCODE 3:2
`define CRI_F_TXE 2:0
`define CRI_F_IRQ 3:0

// Reset values.
`define CRI_RIER_RST 8'h00
`define CRI_TFLG_RST 3'h7

// Error state thresholds and codes.
`define CRI_WRN_CNT 9'h060
`define CRI_ERR_CNT 9'h080
`define CRI_BOFF_CNT 9'h100
`define CRI_ST_OK 2'h0
`define CRI_ST_WRN 2'h1
`define CRI_ST_ERR 2'h2
`define CRI_ST_BOFF 2'h3

// Sensitivity codes.
`define CRI_SENS_BOFF 2'h1
`define CRI_SENS_ERR 2'h2
`define CRI_SENS_ALL 2'h3

`endif

// >>> cri_pkg.sv
/*
  Types shared by the receive interrupt enable block.
  Assumes nothing beyond the constants header.
*/
package cri_pkg;
  typedef logic [7:0] cri_addr_t;   // APB byte address.
  typedef logic [31:0] cri_word_t;  // APB data word.
  typedef logic [1:0] cri_code_t;   // Error state code.
endpackage : cri_pkg

// >>> cri_if.sv
/*
  Carrier between the APB slave and the register logic.
  Assumes one clock; wr is a one-cycle pulse at transfer completion.
*/
`timescale 1ns/10ps
`default_nettype none
interface cri_if;
  logic wr;           // Write takes effect this cycle.
  logic [7:0] addr;   // Byte address of the transfer.
  logic [7:0] wdata;  // Low byte of the write data.
  logic [7:0] rdata;  // Read value of the addressed register.
  logic err;          // Addressed word is unmapped or misaligned.
  modport slv (output wr, output addr, output wdata,
               input rdata, input err);
  modport regs (input wr, input addr, input wdata,
                output rdata, output err);
endinterface : cri_if
`default_nettype wire

// >>> cri_apb.sv
/*
  APB slave front end: one wait state, then pready with read data.
  Assumes a standard APB master on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cri_apb (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire cri_pkg::cri_addr_t paddr,
  input wire cri_pkg::cri_word_t pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  cri_if.slv bus
);
  import cri_pkg::*;

  typedef struct packed {
    logic rdy;
    logic [7:0] rd;
    logic err;
  } cri_apb_s;

  cri_apb_s st_q, st_d;  // Whole slave state.
  logic access;          // Access phase in progress.

  assign access = psel & penable;
  assign bus.addr = paddr;
  assign bus.wdata = pwdata[7:0];
  // The write lands on the very edge where pready is seen high.
  assign bus.wr = access & st_q.rdy & pwrite;
  assign prdata = {24'h000000, st_q.rd};
  assign pready = st_q.rdy;
  assign pslverr = st_q.err;

  // The first access cycle captures the answer, the second shows it.
  always_comb begin
    st_d = st_q;
    st_d.rdy = access & ~st_q.rdy;
    if (access & ~st_q.rdy) begin
      st_d.rd = pwrite ? 8'h00 : bus.rdata;
      st_d.err = bus.err;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : cri_apb
`default_nettype wire

// >>> cri_stat.sv
/*
  Error state tracker: encodes one error count, freezes while a status
  change is pending, and reports qualifying changes.
  Assumes counts and bus-off come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cri_params.svh"
module cri_stat (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [8:0] count,
  input wire logic bus_off,
  input wire logic [1:0] sens,
  input wire logic hold,
  output cri_pkg::cri_code_t code,
  output logic change
);
  import cri_pkg::*;

  typedef struct packed {
    cri_code_t code;
  } cri_stat_s;

  cri_stat_s st_q, st_d;  // Shown state code.
  cri_code_t nxt;         // Live state from the count.
  logic qual;             // Change is within the sensitivity.

  assign code = st_q.code;

  // Leaving bus-off goes straight to OK, as no other exit exists.
  always_comb begin
    if (bus_off) begin
      nxt = `CRI_ST_BOFF;
    end else if (st_q.code == `CRI_ST_BOFF) begin
      nxt = `CRI_ST_OK;
    end else if (count < `CRI_WRN_CNT) begin
      nxt = `CRI_ST_OK;
    end else if (count < `CRI_ERR_CNT) begin
      nxt = `CRI_ST_WRN;
    end else begin
      nxt = `CRI_ST_ERR;
    end
  end

  // Sensitivity decides which transitions count as a change.
  always_comb begin
    case (sens)
      `CRI_SENS_BOFF: qual = (st_q.code == `CRI_ST_BOFF) |
                             (nxt == `CRI_ST_BOFF);
      `CRI_SENS_ERR: qual = st_q.code[1] | nxt[1];
      `CRI_SENS_ALL: qual = 1'b1;
      default: qual = 1'b0;
    endcase
  end

  // The code follows the count only while nothing is pending.
  always_comb begin
    st_d = st_q;
    if (!hold) begin
      st_d.code = nxt;
    end
    change = ~hold & (nxt != st_q.code) & qual;
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  enc_ok_a: assert property (
    (!hold && !bus_off && count < `CRI_WRN_CNT &&
     st_q.code != `CRI_ST_BOFF) |=> st_q.code == `CRI_ST_OK)
    else $error("state code not OK below warning count");
  force_ok_a: assert property (
    (!hold && !bus_off && st_q.code == `CRI_ST_BOFF)
      |=> st_q.code == `CRI_ST_OK)
    else $error("bus-off exit did not force OK");
  code_hold_a: assert property (
    hold |=> $stable(st_q.code))
    else $error("state code moved while change pending");
endmodule : cri_stat
`default_nettype wire

// >>> tb_can_rx_interrupt_enable.sv
/*
  Self-checking bench for the receive interrupt enable block.
  Assumes the design files and the constants header are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cri_params.svh"
module tb_can_rx_interrupt_enable;
  import cri_pkg::*;
  // Byte addresses are four times the word index.
  localparam cri_addr_t A_RFLG = {`CRI_IDX_RFLG, 2'b00};
  localparam cri_addr_t A_RIER = {`CRI_IDX_RIER, 2'b00};
  localparam cri_addr_t A_TFLG = {`CRI_IDX_TFLG, 2'b00};
  localparam cri_addr_t A_TIER = {`CRI_IDX_TIER, 2'b00};
  localparam cri_addr_t A_ISTS = {`CRI_IDX_ISTS, 2'b00};
  localparam cri_addr_t A_ICLR = {`CRI_IDX_ICLR, 2'b00};
  localparam cri_addr_t A_IEN = {`CRI_IDX_IEN, 2'b00};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  cri_addr_t paddr = 8'h00;
  cri_word_t pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic init_request = 1'b0;
  logic init_acknowledge = 1'b0;
  logic wakeup_event = 1'b0;
  logic overrun_event = 1'b0;
  logic rx_full_event = 1'b0;
  logic [2:0] tx_empty_set = 3'h0;
  logic [7:0] rx_err_count = 8'h00;
  logic [8:0] tx_err_count = 9'h000;
  logic wakeup_irq;
  logic error_irq;
  logic rx_irq;
  logic tx_irq;
  logic irq;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  cri_top DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .init_request(init_request),
    .init_acknowledge(init_acknowledge), .wakeup_event(wakeup_event),
    .overrun_event(overrun_event), .rx_full_event(rx_full_event),
    .tx_empty_set(tx_empty_set), .rx_err_count(rx_err_count),
    .tx_err_count(tx_err_count), .wakeup_irq(wakeup_irq),
    .error_irq(error_irq), .rx_irq(rx_irq), .tx_irq(tx_irq), .irq(irq));

  // The clock toggles every half period of 12.5 ns.
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks.

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic w, input cri_addr_t a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // No limit here: only the bench timeout may end a hung wait.
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    // The slave inserts exactly one wait state.
    chk("pready wait", 32'h1, 32'(n));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Write without error expected.
  task automatic wr(input cri_addr_t a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk("write error", 32'h0, {31'h0, err});
  endtask : wr

  // Read and compare the whole word, upper bits zero.
  task automatic rdc(input string what, input cri_addr_t a,
                     input logic [7:0] e);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 8'h00, rd, err);
    chk(what, {24'h000000, e}, rd);
    chk("read error", 32'h0, {31'h0, err});
  endtask : rdc

  // Waits a number of edges so flags and requests settle.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Clears pending flags twice, since a frozen code may re-raise one.
  task automatic clear_flags;
    wr(A_RFLG, 8'hc3);
    tick(4);
    wr(A_RFLG, 8'hc3);
    tick(4);
  endtask : clear_flags

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.

  // Reset values, and an unmapped word answers with an error.
  task automatic t_reset;
    logic [31:0] rd;
    logic err;
    rdc("enable reset", A_RIER, `CRI_RIER_RST);
    rdc("tx flag reset", A_TFLG, 8'h07);
    rdc("tx enable reset", A_TIER, 8'h00);
    rdc("rx flag reset", A_RFLG, 8'h00);
    apb(1'b0, 8'h3c, 8'h00, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    rdc("clear reads zero", A_ICLR, 8'h00);
    chk("irq idle", 32'h0,
        {27'h0, wakeup_irq, error_irq, rx_irq, tx_irq, irq});
    $display("Test reset done");
  endtask : t_reset

  // Init mode holds enables and tx registers, keeps sensitivities.
  task automatic t_init;
    wr(A_RIER, 8'hff);
    rdc("enable write", A_RIER, 8'hff);
    wr(A_TFLG, 8'h01);
    rdc("tx flag w1c", A_TFLG, 8'h06);
    wr(A_TFLG, 8'h00);
    rdc("tx flag zero write", A_TFLG, 8'h06);
    wr(A_TIER, 8'h07);
    @(posedge clk);
    init_request <= 1'b1;
    init_acknowledge <= 1'b1;
    tick(2);
    rdc("enable in init", A_RIER, `CRI_SENS_MASK);
    rdc("tx flag in init", A_TFLG, 8'h07);
    rdc("tx enable in init", A_TIER, 8'h00);
    @(posedge clk);
    init_acknowledge <= 1'b0;
    tick(2);
    wr(A_RIER, 8'h41);
    rdc("write while requested", A_RIER, `CRI_SENS_MASK);
    @(posedge clk);
    init_request <= 1'b0;
    tick(2);
    wr(A_RIER, 8'h00);
    rdc("write after init", A_RIER, 8'h00);
    $display("Test init done");
  endtask : t_init

  // Wake-up, overrun and receive-full each raise their request only through their enable.
  task automatic t_sources;
    logic [7:0] fl;
    logic [7:0] en;
    logic g;
    for (int i = 0; i < 3; i++) begin
      fl = (i == 0) ? 8'h80 : (i == 1) ? 8'h02 : 8'h01;
      en = fl;
      @(posedge clk);
      wakeup_event <= (i == 0);
      overrun_event <= (i == 1);
      rx_full_event <= (i == 2);
      @(posedge clk);
      wakeup_event <= 1'b0;
      overrun_event <= 1'b0;
      rx_full_event <= 1'b0;
      tick(4);
      g = (i == 0) ? wakeup_irq : (i == 1) ? error_irq : rx_irq;
      chk("masked request", 32'h0, {31'h0, g});
      rdc("source flag", A_RFLG, fl);
      wr(A_RIER, en);
      tick(3);
      g = (i == 0) ? wakeup_irq : (i == 1) ? error_irq : rx_irq;
      chk("enabled request", 32'h1, {31'h0, g});
      wr(A_RFLG, fl);
      tick(3);
      g = (i == 0) ? wakeup_irq : (i == 1) ? error_irq : rx_irq;
      chk("cleared request", 32'h0, {31'h0, g});
      rdc("flag cleared", A_RFLG, 8'h00);
    end
    $display("Test sources done");
  endtask : t_sources

  // Summary interrupt: sticky status, mask and clear.
  task automatic t_summary;
    // Earlier scenarios left sticky status behind; start from clean.
    wr(A_ICLR, 8'h0f);
    rdc("status idle", A_ISTS, 8'h00);
    wr(A_IEN, 8'h04);
    @(posedge clk);
    rx_full_event <= 1'b1;
    @(posedge clk);
    rx_full_event <= 1'b0;
    tick(5);
    rdc("status rx", A_ISTS, 8'h04);
    chk("summary raised", 32'h1, {31'h0, irq});
    wr(A_IEN, 8'h00);
    tick(2);
    chk("summary masked", 32'h0, {31'h0, irq});
    wr(A_RFLG, 8'h01);
    tick(3);
    wr(A_ICLR, 8'h04);
    tick(2);
    rdc("status cleared", A_ISTS, 8'h00);
    wr(A_RIER, 8'h00);
    $display("Test summary done");
  endtask : t_summary

  // Transmit empty flags gated by their own enables.
  task automatic t_tx;
    wr(A_TIER, 8'h02);
    tick(3);
    chk("tx request", 32'h1, {31'h0, tx_irq});
    wr(A_TFLG, 8'h02);
    tick(3);
    chk("tx request cleared", 32'h0, {31'h0, tx_irq});
    rdc("tx flag after clear", A_TFLG, 8'h05);
    @(posedge clk);
    tx_empty_set <= 3'h2;
    @(posedge clk);
    tx_empty_set <= 3'h0;
    tick(4);
    rdc("tx flag set", A_TFLG, 8'h07);
    chk("tx request again", 32'h1, {31'h0, tx_irq});
    wr(A_TIER, 8'h00);
    $display("Test tx done");
  endtask : t_tx

  // Sensitivity codes, frozen codes, bus-off mirror.
  task automatic t_states;
    logic [7:0] e;
    for (int s = 0; s < 4; s++) begin
      wr(A_RIER, 8'h40 | 8'(s << 2));
      @(posedge clk);
      tx_err_count <= 9'd128;
      tick(6);
      e = {1'b0, s >= 2, 6'b001000};
      rdc("tx sensitivity", A_RFLG, e);
      chk("status irq", {31'h0, s >= 2}, {31'h0, error_irq});
      @(posedge clk);
      tx_err_count <= 9'd0;
      tick(4);
      clear_flags();
    end
    wr(A_RIER, 8'h4c);
    @(posedge clk);
    tx_err_count <= 9'd96;
    tick(6);
    rdc("warning code", A_RFLG, 8'h44);
    @(posedge clk);
    tx_err_count <= 9'd128;
    tick(6);
    rdc("frozen code", A_RFLG, 8'h44);
    wr(A_RFLG, 8'h40);
    tick(6);
    rdc("released code", A_RFLG, 8'h48);
    @(posedge clk);
    tx_err_count <= 9'd0;
    tick(4);
    clear_flags();
    wr(A_RIER, 8'h50);
    @(posedge clk);
    tx_err_count <= 9'd256;
    tick(6);
    rdc("bus-off codes", A_RFLG, 8'h7c);
    @(posedge clk);
    tx_err_count <= 9'd0;
    tick(4);
    clear_flags();
    rdc("rx back to ok", A_RFLG, 8'h00);
    wr(A_RIER, 8'h70);
    @(posedge clk);
    rx_err_count <= 8'd96;
    tick(6);
    rdc("rx warning", A_RFLG, 8'h50);
    @(posedge clk);
    rx_err_count <= 8'd0;
    tick(4);
    clear_flags();
    $display("Test states done");
  endtask : t_states

  ////////////////////////////////////////////////////////////////////////
  // Verdict and timeout.

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("Checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // A hung handshake is cut short well beyond the expected run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // Main sequence: reset for 8 cycles, then every scenario in turn.
  initial begin
    tick(8);
    resetn <= 1'b1;
    t_reset();
    t_init();
    t_sources();
    t_summary();
    t_tx();
    t_states();
    summarize();
  end
endmodule : tb_can_rx_interrupt_enable
`default_nettype wire
